// [core/ext_mem_pkg.sv]
/*
 * Shared constants and carrier types for the external memory write strobe
 * and program/data select block.
 * Assumes a single 100 MHz system clock and a synchronous active-high reset.
 */
package ext_mem_pkg;

    // ==========================================================
    // Clock and cycle timing
    // ==========================================================
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SETUP_TIME_NS  = 10;
    localparam int STROBE_TIME_NS = 20;
    localparam int HOLD_TIME_NS   = 10;
    // Least times round up to whole cycles, never below one
    localparam int SETUP_CYCLES   = ((SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ?
                                    1 : ((SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int STROBE_CYCLES  = ((STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ?
                                    1 : ((STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int HOLD_CYCLES    = ((HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ?
                                    1 : ((HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // Widths and field positions
    // ==========================================================
    localparam int ADDR_WIDTH        = 24;
    localparam int DATA_WIDTH        = 16;
    localparam int PULLUP_REG_WIDTH  = 16;
    localparam int PROG_SEL_PU_BIT   = 8;
    localparam int DATA_SEL_PU_BIT   = 9;
    localparam int PIN_COUNT         = 2;
    localparam int PROG_SEL_PIN      = 0;
    localparam int DATA_SEL_PIN      = 1;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [PIN_COUNT-1:0]  RESET_GPIO_MODE = 2'h0;
    localparam logic [DATA_WIDTH-1:0] RESET_DATA      = 16'h0000;
    localparam logic [ADDR_WIDTH-1:0] RESET_ADDR      = 24'h000000;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic                  write;
        logic                  program_space;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
    } mem_req_type;

    typedef struct packed {
        logic [PIN_COUNT-1:0] gpio_mode;
        logic [PIN_COUNT-1:0] gpio_dir_out;
        logic [PIN_COUNT-1:0] gpio_value;
    } portd_cfg_type;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_SETUP,
        BUS_STROBE,
        BUS_HOLD
    } bus_state_type;

endpackage : ext_mem_pkg

// [core/select_pin_mux.sv]
/*
 * One shared pin: chip-select function or port D general-purpose pin,
 * with a registered output, active-low output enable and pull-up control.
 * Assumes the function level and drive request are next-cycle values.
 */
`timescale 1ns/100ps
module select_pin_mux (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Configuration
    input  wire logic gpio_mode,
    input  wire logic gpio_dir_out,
    input  wire logic gpio_value,
    input  wire logic pullup_enable,
    // Chip-select function
    input  wire logic func_level_n,
    input  wire logic func_drive,
    // Pin
    input  wire logic pin_in,
    output logic      pin_out,
    output logic      pin_oe_n,
    output logic      pin_pullup,
    output logic      gpio_in_value
);

    logic next_pin_out;
    logic next_pin_oe_n;
    logic next_pin_pullup;
    logic next_gpio_in_value;

    always_comb begin
        next_pin_pullup    = pullup_enable;
        next_gpio_in_value = pin_in;
        if (gpio_mode) begin
            next_pin_out  = gpio_value;
            next_pin_oe_n = ~gpio_dir_out;
        end else begin
            next_pin_out  = func_level_n;
            next_pin_oe_n = ~func_drive;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_out       <= 1'b1;
            pin_oe_n      <= 1'b1;
            pin_pullup    <= 1'b1;
            gpio_in_value <= 1'b1;
        end else begin
            pin_out       <= next_pin_out;
            pin_oe_n      <= next_pin_oe_n;
            pin_pullup    <= next_pin_pullup;
            gpio_in_value <= next_gpio_in_value;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    gpio_out_drive_a: assert property (
        $past(gpio_mode) && $past(gpio_dir_out) |-> !pin_oe_n && pin_out == $past(gpio_value))
        else $error("gpio output not driven with its value");

    gpio_in_float_a: assert property (
        $past(gpio_mode) && !$past(gpio_dir_out) |-> pin_oe_n)
        else $error("gpio input pin is driven");

    pin_pullup_a: assert property (
        pin_pullup == $past(pullup_enable))
        else $error("pin pull-up does not follow its enable bit");

endmodule : select_pin_mux

// [core/ext_mem_write_and_selects.sv]
/*
 * External memory write strobe, read strobe and program/data memory selects,
 * with idle drive control, pull-up control and port D fallback on the selects.
 * Assumes requests and configuration come synchronous to clk_sys and that the
 * pin wires are resolved outside from the output enables.
 */
`timescale 1ns/100ps
module ext_mem_write_and_selects #(
    parameter int SETUP_COUNT  = ext_mem_pkg::SETUP_CYCLES,
    parameter int STROBE_COUNT = ext_mem_pkg::STROBE_CYCLES,
    parameter int HOLD_COUNT   = ext_mem_pkg::HOLD_CYCLES,
    parameter int COUNT_WIDTH  = 4
) (
    // Clock and reset
    input  wire logic                                   clk_sys,
    input  wire logic                                   rst,
    // Access request
    input  wire logic                                   req_valid,
    input  wire ext_mem_pkg::mem_req_type               req,
    output logic                                        req_ready,
    output logic [ext_mem_pkg::DATA_WIDTH-1:0]          rdata,
    output logic                                        rdata_valid,
    // Control bits
    input  wire logic                                   idle_drive_keep_bit,
    input  wire logic                                   pullup_disable_ctrl,
    input  wire logic [ext_mem_pkg::PULLUP_REG_WIDTH-1:0] portd_pullup_enable_reg,
    input  wire logic                                   portd_cfg_load,
    input  wire ext_mem_pkg::portd_cfg_type             portd_cfg,
    output logic [ext_mem_pkg::PIN_COUNT-1:0]           portd_in_value,
    // Strobes
    output logic                                        write_strobe_n,
    output logic                                        write_strobe_oe_n,
    output logic                                        write_strobe_pullup,
    output logic                                        read_strobe_n,
    output logic                                        read_strobe_oe_n,
    // Address and data bus
    output logic [ext_mem_pkg::ADDR_WIDTH-1:0]          addr_out,
    output logic [ext_mem_pkg::DATA_WIDTH-1:0]          data_out,
    output logic                                        data_oe_n,
    input  wire logic [ext_mem_pkg::DATA_WIDTH-1:0]     data_in,
    // Select pins
    input  wire logic                                   program_mem_select_in,
    output logic                                        program_mem_select_n,
    output logic                                        program_mem_select_oe_n,
    output logic                                        program_mem_select_pullup,
    input  wire logic                                   data_mem_select_in,
    output logic                                        data_mem_select_n,
    output logic                                        data_mem_select_oe_n,
    output logic                                        data_mem_select_pullup
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (SETUP_COUNT < 1 || STROBE_COUNT < 1 || HOLD_COUNT < 1) begin : bad_count
        $error("phase counts must be at least one cycle");
    end
    if (SETUP_COUNT >= (1 << COUNT_WIDTH) || STROBE_COUNT >= (1 << COUNT_WIDTH)
        || HOLD_COUNT >= (1 << COUNT_WIDTH)) begin : wide_count
        $error("phase counts do not fit the counter width");
    end

    localparam logic [COUNT_WIDTH-1:0] SETUP_LAST  = COUNT_WIDTH'(SETUP_COUNT - 1);
    localparam logic [COUNT_WIDTH-1:0] STROBE_LAST = COUNT_WIDTH'(STROBE_COUNT - 1);
    localparam logic [COUNT_WIDTH-1:0] HOLD_LAST   = COUNT_WIDTH'(HOLD_COUNT - 1);

    // ==========================================================
    // Port D configuration
    // ==========================================================
    ext_mem_pkg::portd_cfg_type pin_cfg;
    ext_mem_pkg::portd_cfg_type next_pin_cfg;

    always_comb begin
        next_pin_cfg = pin_cfg;
        if (portd_cfg_load) begin
            next_pin_cfg = portd_cfg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_cfg.gpio_mode    <= ext_mem_pkg::RESET_GPIO_MODE;
            pin_cfg.gpio_dir_out <= '0;
            pin_cfg.gpio_value   <= '1;
        end else begin
            pin_cfg <= next_pin_cfg;
        end
    end

    // ==========================================================
    // Bus cycle sequencer
    // ==========================================================
    ext_mem_pkg::bus_state_type            state;
    ext_mem_pkg::bus_state_type            next_state;
    logic [COUNT_WIDTH-1:0]                count;
    logic [COUNT_WIDTH-1:0]                next_count;
    ext_mem_pkg::mem_req_type              cur;
    ext_mem_pkg::mem_req_type              next_cur;
    logic                                  next_req_ready;
    logic [ext_mem_pkg::DATA_WIDTH-1:0]    next_rdata;
    logic                                  next_rdata_valid;
    logic                                  next_write_strobe_n;
    logic                                  next_write_strobe_oe_n;
    logic                                  next_write_strobe_pullup;
    logic                                  next_read_strobe_n;
    logic                                  next_read_strobe_oe_n;
    logic [ext_mem_pkg::ADDR_WIDTH-1:0]    next_addr_out;
    logic [ext_mem_pkg::DATA_WIDTH-1:0]    next_data_out;
    logic                                  next_data_oe_n;
    logic                                  next_active;
    logic                                  next_drive;
    logic                                  next_prog_sel_n;
    logic                                  next_data_sel_n;

    always_comb begin
        next_state       = state;
        next_count       = count;
        next_cur         = cur;
        next_rdata       = rdata;
        next_rdata_valid = 1'b0;
        case (state)
            ext_mem_pkg::BUS_IDLE: begin
                if (req_valid) begin
                    next_cur   = req;
                    next_count = '0;
                    next_state = ext_mem_pkg::BUS_SETUP;
                end
            end
            ext_mem_pkg::BUS_SETUP: begin
                next_count = count + 1'b1;
                if (count == SETUP_LAST) begin
                    next_count = '0;
                    next_state = ext_mem_pkg::BUS_STROBE;
                end
            end
            ext_mem_pkg::BUS_STROBE: begin
                next_count = count + 1'b1;
                if (count == STROBE_LAST) begin
                    next_count = '0;
                    next_state = ext_mem_pkg::BUS_HOLD;
                    if (!cur.write) begin
                        next_rdata       = data_in;
                        next_rdata_valid = 1'b1;
                    end
                end
            end
            ext_mem_pkg::BUS_HOLD: begin
                next_count = count + 1'b1;
                if (count == HOLD_LAST) begin
                    next_count = '0;
                    next_state = ext_mem_pkg::BUS_IDLE;
                end
            end
            default: begin
                next_state = ext_mem_pkg::BUS_IDLE;
            end
        endcase

        next_req_ready = (next_state == ext_mem_pkg::BUS_IDLE);
        next_active    = (next_state != ext_mem_pkg::BUS_IDLE);
        next_drive     = next_active | idle_drive_keep_bit;

        // Strobe low only in the strobe phase; rise ends it for the memory
        next_write_strobe_n    = ~(next_state == ext_mem_pkg::BUS_STROBE && next_cur.write);
        next_read_strobe_n     = ~(next_state == ext_mem_pkg::BUS_STROBE && !next_cur.write);
        next_write_strobe_oe_n = ~next_drive;
        next_read_strobe_oe_n  = ~next_drive;
        next_write_strobe_pullup = ~pullup_disable_ctrl;

        // Address and data span setup, strobe and hold
        next_addr_out  = next_active ? next_cur.addr : addr_out;
        next_data_out  = next_active ? next_cur.wdata : data_out;
        next_data_oe_n = ~(next_active && next_cur.write);

        next_prog_sel_n = ~(next_active && next_cur.program_space);
        next_data_sel_n = ~(next_active && !next_cur.program_space);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state               <= ext_mem_pkg::BUS_IDLE;
            count               <= '0;
            cur                 <= '0;
            req_ready           <= 1'b0;
            rdata               <= ext_mem_pkg::RESET_DATA;
            rdata_valid         <= 1'b0;
            write_strobe_n      <= 1'b1;
            write_strobe_oe_n   <= 1'b1;
            write_strobe_pullup <= 1'b1;
            read_strobe_n       <= 1'b1;
            read_strobe_oe_n    <= 1'b1;
            addr_out            <= ext_mem_pkg::RESET_ADDR;
            data_out            <= ext_mem_pkg::RESET_DATA;
            data_oe_n           <= 1'b1;
        end else begin
            state               <= next_state;
            count               <= next_count;
            cur                 <= next_cur;
            req_ready           <= next_req_ready;
            rdata               <= next_rdata;
            rdata_valid         <= next_rdata_valid;
            write_strobe_n      <= next_write_strobe_n;
            write_strobe_oe_n   <= next_write_strobe_oe_n;
            write_strobe_pullup <= next_write_strobe_pullup;
            read_strobe_n       <= next_read_strobe_n;
            read_strobe_oe_n    <= next_read_strobe_oe_n;
            addr_out            <= next_addr_out;
            data_out            <= next_data_out;
            data_oe_n           <= next_data_oe_n;
        end
    end

    // ==========================================================
    // Select pins
    // ==========================================================
    select_pin_mux u_prog_sel (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .gpio_mode     (pin_cfg.gpio_mode[ext_mem_pkg::PROG_SEL_PIN]),
        .gpio_dir_out  (pin_cfg.gpio_dir_out[ext_mem_pkg::PROG_SEL_PIN]),
        .gpio_value    (pin_cfg.gpio_value[ext_mem_pkg::PROG_SEL_PIN]),
        .pullup_enable (portd_pullup_enable_reg[ext_mem_pkg::PROG_SEL_PU_BIT]),
        .func_level_n  (next_prog_sel_n),
        .func_drive    (next_drive),
        .pin_in        (program_mem_select_in),
        .pin_out       (program_mem_select_n),
        .pin_oe_n      (program_mem_select_oe_n),
        .pin_pullup    (program_mem_select_pullup),
        .gpio_in_value (portd_in_value[ext_mem_pkg::PROG_SEL_PIN])
    );

    select_pin_mux u_data_sel (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .gpio_mode     (pin_cfg.gpio_mode[ext_mem_pkg::DATA_SEL_PIN]),
        .gpio_dir_out  (pin_cfg.gpio_dir_out[ext_mem_pkg::DATA_SEL_PIN]),
        .gpio_value    (pin_cfg.gpio_value[ext_mem_pkg::DATA_SEL_PIN]),
        .pullup_enable (portd_pullup_enable_reg[ext_mem_pkg::DATA_SEL_PU_BIT]),
        .func_level_n  (next_data_sel_n),
        .func_drive    (next_drive),
        .pin_in        (data_mem_select_in),
        .pin_out       (data_mem_select_n),
        .pin_oe_n      (data_mem_select_oe_n),
        .pin_pullup    (data_mem_select_pullup),
        .gpio_in_value (portd_in_value[ext_mem_pkg::DATA_SEL_PIN])
    );

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    write_only_write_a: assert property (
        !write_strobe_n |-> cur.write && state == ext_mem_pkg::BUS_STROBE && read_strobe_n)
        else $error("write strobe low outside a write cycle");

    write_data_driven_a: assert property (
        !write_strobe_n |-> !data_oe_n && data_out == cur.wdata)
        else $error("data bus not driven while write strobe low");

    write_data_hold_a: assert property (
        $rose(write_strobe_n) |-> !data_oe_n && $stable(data_out) && $stable(addr_out))
        else $error("write data changed at the strobe rise");

    strobe_qualifies_a: assert property (
        !write_strobe_n || !read_strobe_n |-> addr_out == cur.addr
        && (pin_cfg.gpio_mode[0] || program_mem_select_n == !cur.program_space)
        && (pin_cfg.gpio_mode[1] || data_mem_select_n == cur.program_space))
        else $error("address or select invalid under a strobe");

    idle_float_a: assert property (
        state == ext_mem_pkg::BUS_IDLE && !$past(idle_drive_keep_bit)
        && !$past(rst) |-> write_strobe_oe_n && read_strobe_oe_n)
        else $error("strobe driven on idle bus with keep bit clear");

    idle_high_a: assert property (
        state == ext_mem_pkg::BUS_IDLE && $past(idle_drive_keep_bit) && !$past(rst)
        |-> !write_strobe_oe_n && write_strobe_n && read_strobe_n
        && (pin_cfg.gpio_mode[0] || (!program_mem_select_oe_n && program_mem_select_n)))
        else $error("idle bus not held high with keep bit set");

    write_pullup_a: assert property (
        !$past(rst) |-> write_strobe_pullup == !$past(pullup_disable_ctrl))
        else $error("write strobe pull-up does not follow the disable bit");

    legacy_reset_a: assert property (
        $past(rst) |-> pin_cfg.gpio_mode == ext_mem_pkg::RESET_GPIO_MODE)
        else $error("selects not in select function after reset");

    prog_select_a: assert property (
        !pin_cfg.gpio_mode[0] && state != ext_mem_pkg::BUS_IDLE && cur.program_space
        |-> !program_mem_select_n && data_mem_select_n)
        else $error("program select not low for program access");

    data_select_a: assert property (
        !pin_cfg.gpio_mode[1] && state != ext_mem_pkg::BUS_IDLE && !cur.program_space
        |-> !data_mem_select_n && program_mem_select_n)
        else $error("data select not low for data access");

    read_latch_a: assert property (
        rdata_valid |-> $rose(read_strobe_n) && data_oe_n && rdata == $past(data_in))
        else $error("read data not latched at read strobe rise");

endmodule : ext_mem_write_and_selects

// [test/ext_sram_model.sv]
/*
 * External static RAM on the parallel bus, sixteen words deep.
 * Assumes the bench hands it the resolved strobes, select, address and data.
 */
`timescale 1ns/100ps
module ext_sram_model (
    // Bus pins
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        sel_n,
    input  wire logic [23:0] addr,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata
);
    logic [15:0] mem [16];
    // ==========================================================
    // Storage
    // ==========================================================
    always @(posedge we_n) begin
        if (!sel_n) mem[addr[3:0]] <= wdata;
    end
    // A released bus shows the inverse, so a stale copy cannot pass
    assign rdata = (!oe_n && !sel_n) ? mem[addr[3:0]] : ~mem[addr[3:0]];
endmodule : ext_sram_model

// [test/tb.sv]
/*
 * Self-checking bench for the write strobe and select block.
 * Assumes the package and the external SRAM model are compiled first.
 */
`timescale 1ns/100ps
module tb;
    logic clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, req_ready, rdata_valid, keep = 1'b0;
    logic pud = 1'b0, cfg_load = 1'b0, ext_lvl = 1'b1, ws_n, ws_oe_n, ws_pu, rs_n, rs_oe_n, d_oe_n;
    logic ps_in, ps_n, ps_oe_n, ps_pu, ds_in, ds_n, ds_oe_n, ds_pu;
    logic [15:0] pu_en = 16'h0300, rdata, data_out, data_in;
    logic [23:0] addr_out;
    logic [1:0] pin_in_value;
    ext_mem_pkg::mem_req_type   req = '0;
    ext_mem_pkg::portd_cfg_type cfg = '0;
    int fails = 0, compares = 0;
    always #5 clk_sys = ~clk_sys;
    assign ps_in = ps_oe_n ? ext_lvl : ps_n;
    assign ds_in = ds_oe_n ? ext_lvl : ds_n;
    ext_mem_write_and_selects i_ext_mem_write_and_selects (
        .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rdata(rdata), .rdata_valid(rdata_valid), .idle_drive_keep_bit(keep),
        .pullup_disable_ctrl(pud), .portd_pullup_enable_reg(pu_en), .portd_cfg_load(cfg_load),
        .portd_cfg(cfg), .portd_in_value(pin_in_value), .write_strobe_n(ws_n),
        .write_strobe_oe_n(ws_oe_n), .write_strobe_pullup(ws_pu), .read_strobe_n(rs_n),
        .read_strobe_oe_n(rs_oe_n), .addr_out(addr_out), .data_out(data_out), .data_oe_n(d_oe_n),
        .data_in(data_in), .program_mem_select_in(ps_in), .program_mem_select_n(ps_n),
        .program_mem_select_oe_n(ps_oe_n), .program_mem_select_pullup(ps_pu),
        .data_mem_select_in(ds_in), .data_mem_select_n(ds_n), .data_mem_select_oe_n(ds_oe_n),
        .data_mem_select_pullup(ds_pu));
    ext_sram_model i_ext_sram_model (.we_n(ws_n), .oe_n(rs_n), .sel_n(ps_n & ds_n),
        .addr(addr_out), .wdata(data_out), .rdata(data_in));
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic idle_pins(input logic k);
        @(negedge clk_sys);
        check({ws_oe_n, rs_oe_n, ps_oe_n, ds_oe_n}, k ? 24'h0 : 24'hF);
        check({ws_n, ps_n, ds_n}, 24'h7);
    endtask : idle_pins
    task automatic access(input logic wr, input logic prog, input logic [23:0] a,
                          input logic [15:0] d);
        logic [23:0] n, v;
        n = '0;
        v = '0;
        for (int i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clk_sys);
        req_valid = 1'b1;
        req = '{wr, prog, a, d};
        @(negedge clk_sys);
        req_valid = 1'b0;
        for (int i = 0; i < 20 && req_ready !== 1'b1; i++) begin
            if ((wr ? ws_n : rs_n) === 1'b0) begin
                n++;
                check(addr_out, a);
                check(d_oe_n, !wr);
                check({ps_n, ds_n}, prog ? 24'h1 : 24'h2);
                check(wr ? rs_n : ws_n, 24'h1);
                if (wr) check(data_out, d);
            end
            if (rdata_valid === 1'b1) v++;
            @(negedge clk_sys);
        end
        check(n, 24'(ext_mem_pkg::STROBE_CYCLES));
        check(req_ready, 24'h1);
        check(v, !wr);
        if (!wr) check(rdata, d);
    endtask : access
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic reset_state;
        check({ws_oe_n, ps_oe_n, ds_oe_n, ws_pu, ps_pu, ds_pu, req_ready, rdata_valid}, 24'hFC);
        rst = 1'b0;
        idle_pins(1'b0);
    endtask : reset_state
    task automatic write_read_back;
        access(1'b1, 1'b1, 24'hABC005, 16'hA5A5);
        access(1'b1, 1'b0, 24'h123406, 16'h5A5A);
        access(1'b0, 1'b1, 24'hABC005, 16'hA5A5);
        access(1'b0, 1'b0, 24'h123406, 16'h5A5A);
    endtask : write_read_back
    task automatic keep_driven;
        keep = 1'b1;
        repeat (2) idle_pins(1'b1);
        access(1'b1, 1'b0, 24'hFFFFFF, 16'hFFFF);
        idle_pins(1'b1);
    endtask : keep_driven
    task automatic pullups;
        pud = 1'b1;
        pu_en = 16'h0100;
        repeat (2) @(negedge clk_sys);
        check({ws_pu, ps_pu, ds_pu}, 24'h2);
        pu_en = 16'h0200;
        repeat (2) @(negedge clk_sys);
        check({ps_pu, ds_pu}, 24'h1);
    endtask : pullups
    task automatic port_pins;
        ext_lvl = 1'b0;
        cfg = '{2'h3, 2'h1, 2'h0};
        cfg_load = 1'b1;
        @(negedge clk_sys);
        cfg_load = 1'b0;
        repeat (3) @(negedge clk_sys);
        check({ps_oe_n, ps_n, ds_oe_n, pin_in_value}, 24'h4);
    endtask : port_pins
    initial begin
        repeat (10) @(negedge clk_sys);
        reset_state();
        write_read_back();
        keep_driven();
        pullups();
        port_pins();
        final_report();
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        fails++;
        final_report();
    end
endmodule : tb
